// File: card16_cycle_timing_gen.sv
// 16-bit card cycle sequencer with two programmable timer sets
`timescale 1ns/1ps
module card16_cycle_timing_gen (
  // Clock and reset
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_reset,
  // Clock options
  input  wire logic                     i_alt_clk_sel,
  input  wire logic                     i_clk_divide,
  input  wire logic                     i_alt_clk_tick,
  // Timing register index/data port
  input  wire logic [7:0]               i_reg_index,
  input  wire logic                     i_reg_wr,
  input  wire logic [7:0]               i_reg_wdata,
  input  wire logic                     i_reg_rd,
  output logic [7:0]                    o_reg_rdata,
  // Cycle request and answer
  input  wire logic                     i_cyc_start,
  input  wire card16_pkg::cyc_req_type  i_cyc_req,
  output logic                          o_cyc_busy,
  output logic                          o_cyc_done,
  output logic [15:0]                   o_cyc_rdata,
  // Card pins
  input  wire logic                     i_wait_n,
  input  wire logic                     i_iois16_n,
  input  wire logic [15:0]              i_card_data,
  output card16_pkg::card_pins_type     o_card
);

  typedef struct packed {
    card16_pkg::phase_type     phase;
    logic [8:0]                cnt;
    logic [2:0]                win;
    logic                      iois_seen;
    logic                      wait_seen;
    logic                      align;
    card16_pkg::cyc_req_type   req;
    card16_pkg::card_pins_type pins;
    logic [15:0]               rdata;
    logic                      done;
    logic                      busy;
    logic [7:0]                reg_rdata;
    logic [5:0][7:0]           tregs;
  } gen_state_type;

  gen_state_type q;
  gen_state_type d;
  logic          tick;
  logic [2:0]    slot;
  logic          slot_ok;

  // Index to register slot decode, used by reads and writes
  function automatic logic [3:0] decode_index(input logic [7:0] idx);
    logic [7:0] off;
    off = idx - card16_pkg::IDX_SETUP0;
    if (idx >= card16_pkg::IDX_SETUP0 && idx <= card16_pkg::IDX_RECOVERY1)
      decode_index = {1'b1, off[2:0]};
    else
      decode_index = 4'h0;
  endfunction

  // Programmed phase count from the chosen timer set
  function automatic logic [7:0] phase_count(input logic [5:0][7:0] regs,
                                             input logic set_sel,
                                             input int kind);
    phase_count = regs[(set_sel ? card16_pkg::REGS_PER_SET : 0) + kind];
  endfunction

  function automatic gen_state_type reset_state();
    gen_state_type s;
    s = '0;
    s.phase = card16_pkg::PH_IDLE;
    s.pins  = card16_pkg::PINS_IDLE;
    s.tregs[0] = card16_pkg::RST_SETUP0;
    s.tregs[1] = card16_pkg::RST_COMMAND0;
    s.tregs[2] = card16_pkg::RST_RECOVERY0;
    s.tregs[3] = card16_pkg::RST_SET1;
    s.tregs[4] = card16_pkg::RST_SET1;
    s.tregs[5] = card16_pkg::RST_SET1;
    reset_state = s;
  endfunction

  // Internal timing clock enable
  card16_clk_tick u_tick (
    .i_sys_clk  (i_sys_clk),
    .i_reset    (i_reset),
    .i_alt_sel  (i_alt_clk_sel),
    .i_divide   (i_clk_divide),
    .i_alt_tick (i_alt_clk_tick),
    .o_tick     (tick)
  );

  assign {slot_ok, slot} = decode_index(i_reg_index);

  // Next-state logic: register port and cycle sequencer
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    if (i_reg_wr && slot_ok)
      d.tregs[slot] = i_reg_wdata;
    if (i_reg_rd)
      d.reg_rdata = slot_ok ? q.tregs[slot] : card16_pkg::READ_ZERO;
    // Opening window for the 16-bit I/O answer
    if (q.phase != card16_pkg::PH_IDLE && q.req.is_io && q.req.word)
    begin
      if (tick && q.win < card16_pkg::IOIS_WIN)
      begin
        d.win = q.win + 3'h1;
        if (!i_iois16_n)
          d.iois_seen = 1'b1;
      end
      if (tick && q.iois_seen && q.phase != card16_pkg::PH_RECOV)
        d.pins.ce2_n = 1'b0;
    end
    case (q.phase)
      card16_pkg::PH_IDLE:
      begin
        if (i_cyc_start)
        begin
          d.req       = i_cyc_req;
          d.phase     = card16_pkg::PH_SETUP;
          d.cnt       = {1'b0, phase_count(q.tregs, i_cyc_req.timer_set,
                                           card16_pkg::SLOT_SETUP)};
          d.win       = 3'h0;
          d.iois_seen = 1'b0;
          d.wait_seen = 1'b0;
          // Unaligned start: the first tick is partial and does not count
          d.align     = ~tick;
          d.busy      = 1'b1;
          d.pins.addr     = i_cyc_req.addr;
          d.pins.reg_n    = ~i_cyc_req.reg_space;
          d.pins.ce1_n    = 1'b0;
          d.pins.ce2_n    = ~(i_cyc_req.word && !i_cyc_req.is_io);
          d.pins.data_out = i_cyc_req.wdata;
          d.pins.data_oe  = i_cyc_req.write;
        end
      end
      card16_pkg::PH_SETUP:
      begin
        if (tick)
        begin
          if (q.align)
            d.align = 1'b0;
          else if (q.cnt == card16_pkg::CNT_ZERO)
          begin
            d.phase = card16_pkg::PH_CMD;
            d.cnt   = {1'b0, phase_count(q.tregs, q.req.timer_set,
                                         card16_pkg::SLOT_COMMAND)};
            d.pins.oe_n   = q.req.is_io | q.req.write;
            d.pins.we_n   = q.req.is_io | ~q.req.write;
            d.pins.iord_n = ~q.req.is_io | q.req.write;
            d.pins.iowr_n = ~q.req.is_io | ~q.req.write;
          end
          else
            d.cnt = q.cnt - card16_pkg::CNT_ONE;
        end
      end
      card16_pkg::PH_CMD, card16_pkg::PH_HOLD:
      begin
        if (tick)
        begin
          if (!i_wait_n)
            d.wait_seen = 1'b1;
          if (q.phase == card16_pkg::PH_HOLD && !i_wait_n)
            d.cnt = q.req.is_io ? card16_pkg::HOLD_IO_LOAD
                                : card16_pkg::HOLD_MEM_LOAD;
          else if (q.cnt != card16_pkg::CNT_ZERO)
            d.cnt = q.cnt - card16_pkg::CNT_ONE;
          else if (q.phase == card16_pkg::PH_CMD && (q.wait_seen || !i_wait_n))
          begin
            d.phase = card16_pkg::PH_HOLD;
            d.cnt   = q.req.is_io ? card16_pkg::HOLD_IO_LOAD
                                  : card16_pkg::HOLD_MEM_LOAD;
          end
          else
          begin
            // Strobe ends: sample read data, keep address for recovery
            d.phase = card16_pkg::PH_RECOV;
            d.cnt   = {1'b0, phase_count(q.tregs, q.req.timer_set,
                       card16_pkg::SLOT_RECOVERY)} + card16_pkg::CNT_ONE;
            d.pins.oe_n   = 1'b1;
            d.pins.we_n   = 1'b1;
            d.pins.iord_n = 1'b1;
            d.pins.iowr_n = 1'b1;
            if (!q.req.write)
              d.rdata = q.pins.ce2_n ? {8'h00, i_card_data[7:0]} : i_card_data;
          end
        end
      end
      card16_pkg::PH_RECOV:
      begin
        if (tick)
        begin
          if (q.cnt == card16_pkg::CNT_ZERO)
          begin
            d.phase = card16_pkg::PH_IDLE;
            d.pins  = card16_pkg::PINS_IDLE;
            d.busy  = 1'b0;
            d.done  = 1'b1;
          end
          else
            d.cnt = q.cnt - card16_pkg::CNT_ONE;
        end
      end
      default:
        d = reset_state();
    endcase
  end

  // State register
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      q <= reset_state();
    else
      q <= d;
  end

  assign o_reg_rdata = q.reg_rdata;
  assign o_cyc_busy  = q.busy;
  assign o_cyc_done  = q.done;
  assign o_cyc_rdata = q.rdata;
  assign o_card      = q.pins;

  // Ticks spent so far in the current phase, for the checks below
  logic [9:0] hc_r;
  logic [7:0] set_setup;
  logic [7:0] set_cmd;
  logic [7:0] set_recov;
  assign set_setup = phase_count(q.tregs, q.req.timer_set,
                                 card16_pkg::SLOT_SETUP);
  assign set_cmd   = phase_count(q.tregs, q.req.timer_set,
                                 card16_pkg::SLOT_COMMAND);
  assign set_recov = phase_count(q.tregs, q.req.timer_set,
                                 card16_pkg::SLOT_RECOVERY);
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      hc_r <= 10'h000;
    else if (d.phase != q.phase)
      hc_r <= 10'h000;
    else if (tick && !q.align)
      hc_r <= hc_r + 10'h001;
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  a_setup_length: assert property (
    (q.phase == card16_pkg::PH_SETUP && d.phase == card16_pkg::PH_CMD)
    |-> (hc_r + 10'h001 == {2'b00, set_setup} + 10'h001))
    else $error("setup phase length differs from setup factor");
  a_command_length: assert property (
    (q.phase == card16_pkg::PH_CMD && d.phase == card16_pkg::PH_RECOV)
    |-> (hc_r + 10'h001 == {2'b00, set_cmd} + 10'h001))
    else $error("command phase length differs from command factor");
  a_recovery_length: assert property (
    (q.phase == card16_pkg::PH_RECOV && d.phase == card16_pkg::PH_IDLE)
    |-> (hc_r + 10'h001 == {2'b00, set_recov} + 10'h002))
    else $error("recovery phase length wrong");
  a_reset_values: assert property (disable iff (1'b0)
    $fell(i_reset) |-> (q.tregs[0] == card16_pkg::RST_SETUP0 &&
      q.tregs[1] == card16_pkg::RST_COMMAND0 &&
      q.tregs[2] == card16_pkg::RST_RECOVERY0))
    else $error("timer set 0 reset values wrong");
  a_wait_stretch: assert property (
    (q.phase inside {card16_pkg::PH_CMD, card16_pkg::PH_HOLD} && !i_wait_n)
    |=> (q.phase inside {card16_pkg::PH_CMD, card16_pkg::PH_HOLD}))
    else $error("strobe ended while wait asserted");
  a_hold_after_wait: assert property (
    (q.phase == card16_pkg::PH_HOLD && d.phase == card16_pkg::PH_RECOV)
    |-> ($past(i_wait_n) && q.cnt == card16_pkg::CNT_ZERO))
    else $error("command hold after wait too short");
  a_ce2_after_iois: assert property (
    ($fell(o_card.ce2_n) && q.req.is_io) |-> $past(q.iois_seen))
    else $error("upper enable before 16-bit answer seen");
  a_iois_ignored: assert property (
    (q.phase != card16_pkg::PH_IDLE && q.req.is_io && !q.iois_seen)
    |-> o_card.ce2_n)
    else $error("upper enable without 16-bit answer in window");
  a_phase_order: assert property (
    (q.phase == card16_pkg::PH_CMD && $past(q.phase) != card16_pkg::PH_CMD)
    |-> $past(q.phase) == card16_pkg::PH_SETUP)
    else $error("command phase not entered from setup");

  c_mem_read: cover property (o_cyc_done && !q.req.is_io && !q.req.write);
  c_io_word: cover property (q.req.is_io && !o_card.ce2_n && !o_card.iord_n);
  c_wait_hold: cover property (q.phase == card16_pkg::PH_HOLD);

endmodule

// File: card16_pkg.sv
// Constants, types and register map for the 16-bit card cycle timing generator
// What this block does
// - Setup factor is setup count plus one; address and enables precede the strobe, save the word I/O upper enable.
// - Command factor is command count plus one; strobe held that many periods.
// - Recovery keeps address and write data for recovery factor plus one periods.
// - Timing clock is the system clock, undivided, unless selected otherwise.
// - Timer set 0 resets to setup 00h, command 07h, recovery 04h.
// - Wait stretches the strobe; then two periods more, three on I/O.
// - Upper card enable for word I/O comes a period after 16-bit is seen.
// - A 16-bit signal outside the opening window is ignored; upper byte off.
package card16_pkg;

  // Register indices on the index/data port
  localparam logic [7:0] IDX_SETUP0    = 8'h3A;
  localparam logic [7:0] IDX_COMMAND0  = 8'h3B;
  localparam logic [7:0] IDX_RECOVERY0 = 8'h3C;
  localparam logic [7:0] IDX_SETUP1    = 8'h3D;
  localparam logic [7:0] IDX_COMMAND1  = 8'h3E;
  localparam logic [7:0] IDX_RECOVERY1 = 8'h3F;
  localparam int         NUM_TREGS     = 6;
  localparam int         REGS_PER_SET  = 3;
  localparam int         SLOT_SETUP    = 0;
  localparam int         SLOT_COMMAND  = 1;
  localparam int         SLOT_RECOVERY = 2;

  // Reset values
  localparam logic [7:0] RST_SETUP0    = 8'h00;
  localparam logic [7:0] RST_COMMAND0  = 8'h07;
  localparam logic [7:0] RST_RECOVERY0 = 8'h04;
  localparam logic [7:0] RST_SET1      = 8'h00;
  localparam logic [7:0] READ_ZERO     = 8'h00;

  // Timing, in ns and in internal clock periods
  localparam int TCP_NS          = 20;
  localparam int MARGIN_NS       = 10;
  localparam int HOLD_MEM_NS     = 2 * TCP_NS;
  localparam int HOLD_IO_NS      = 2 * TCP_NS + MARGIN_NS;
  localparam int IOIS_WIN_NS     = 3 * TCP_NS + MARGIN_NS;
  localparam int HOLD_MEM_TICKS  = (HOLD_MEM_NS + TCP_NS - 1) / TCP_NS;
  localparam int HOLD_IO_TICKS   = (HOLD_IO_NS + TCP_NS - 1) / TCP_NS;
  localparam int IOIS_WIN_TICKS  = IOIS_WIN_NS / TCP_NS;
  localparam logic [8:0] HOLD_MEM_LOAD = 9'(HOLD_MEM_TICKS - 1);
  localparam logic [8:0] HOLD_IO_LOAD  = 9'(HOLD_IO_TICKS - 1);
  localparam logic [2:0] IOIS_WIN      = 3'(IOIS_WIN_TICKS);
  localparam logic [8:0] CNT_ONE       = 9'h001;
  localparam logic [8:0] CNT_ZERO      = 9'h000;

  // Cycle phases
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_SETUP = 3'b001,
    PH_CMD   = 3'b010,
    PH_HOLD  = 3'b011,
    PH_RECOV = 3'b100
  } phase_type;

  // One cycle request from the host side
  typedef struct packed {
    logic        write;
    logic        is_io;
    logic        word;
    logic        reg_space;
    logic        timer_set;
    logic [25:0] addr;
    logic [15:0] wdata;
  } cyc_req_type;

  // Card-facing pins, active-low strobes
  typedef struct packed {
    logic [25:0] addr;
    logic        reg_n;
    logic        ce1_n;
    logic        ce2_n;
    logic        oe_n;
    logic        we_n;
    logic        iord_n;
    logic        iowr_n;
    logic [15:0] data_out;
    logic        data_oe;
  } card_pins_type;

  localparam card_pins_type PINS_IDLE = '{
    addr: 26'h0000000, reg_n: 1'b1, ce1_n: 1'b1, ce2_n: 1'b1, oe_n: 1'b1,
    we_n: 1'b1, iord_n: 1'b1, iowr_n: 1'b1, data_out: 16'h0000,
    data_oe: 1'b0};

endpackage

// File: card16_clk_tick.sv
// Internal timing clock enable: system clock, divided, or alternate source
`timescale 1ns/1ps
module card16_clk_tick (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  // Clock options
  input  wire logic i_alt_sel,
  input  wire logic i_divide,
  input  wire logic i_alt_tick,
  // Enable out
  output logic      o_tick
);

  typedef struct packed {
    logic tick;
    logic half;
  } tick_state_type;

  tick_state_type q;
  tick_state_type d;
  logic           src;

  // Source pulse, then optional divide by two
  always_comb
  begin
    d   = q;
    src = i_alt_sel ? i_alt_tick : 1'b1;
    d.tick = 1'b0;
    if (src)
    begin
      d.half = ~q.half;
      d.tick = i_divide ? q.half : 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      q <= '0;
    else
      q <= d;
  end

  assign o_tick = q.tick;

  a_tick_undivided: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (!i_alt_sel && !i_divide) |=> o_tick)
    else $error("internal clock not undivided system clock");

endmodule

// File: card16_card_model.sv
// Behavioural 16-bit card in its socket: wait, 16-bit I/O and read data
`timescale 1ns/1ps
module card16_card_model (
  // Clock and reset
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_reset,
  // Pins from the adapter
  input  wire card16_pkg::card_pins_type i_card,
  // Behaviour chosen by the bench
  input  wire logic [7:0]                i_wait_len,
  input  wire logic                      i_iois_en,
  input  wire logic                      i_iois_late,
  input  wire logic [15:0]               i_rd_word,
  // Pins to the adapter
  output logic                           o_wait_n,
  output logic                           o_iois16_n,
  output logic [15:0]                    o_card_data
);
  logic       strobe;
  logic       strobe_d;
  logic [7:0] wcnt;

  // Any command strobe active
  assign strobe = !(i_card.oe_n & i_card.we_n & i_card.iord_n & i_card.iowr_n);
  // 16-bit I/O answered once enabled, or in late mode only once strobed
  assign o_iois16_n = !(i_iois_en && !i_card.ce1_n &&
                        (strobe || !i_iois_late));
  // Data only while strobed and not waiting, the inverse otherwise
  assign o_card_data = (strobe && o_wait_n) ? i_rd_word : ~i_rd_word;
  assign o_wait_n = (wcnt == 8'h00);

  // Wait goes low one clock into the strobe, for i_wait_len clocks
  always @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      strobe_d <= 1'b0;
      wcnt     <= 8'h00;
    end
    else
    begin
      strobe_d <= strobe;
      if (strobe && !strobe_d)
        wcnt <= i_wait_len;
      else if (wcnt != 8'h00)
        wcnt <= wcnt - 8'h01;
    end
  end
endmodule

// File: card16_cycle_timing_gen_tb.sv
// Self-checking bench for the 16-bit card cycle timing generator
`timescale 1ns/1ps
module card16_cycle_timing_gen_tb;
  logic                      clk, rst, alt_sel, div, wr, rd;
  logic                      alt_tick = 1'b0;
  logic [7:0]                idx, wdat, rdat, wlen;
  logic                      start, busy, done, wait_n, iois_n, iois_en;
  card16_pkg::cyc_req_type   req;
  logic [15:0]               crd, cdata;
  card16_pkg::card_pins_type card;
  int                        n_mismatch, checks_done;
  int                        cyc = 0;
  int                        su, cm, rc, pw;
  logic                      ce2_lo, ce2_early, held, iois_late;

  card16_cycle_timing_gen uut (
    .i_sys_clk(clk), .i_reset(rst), .i_alt_clk_sel(alt_sel),
    .i_clk_divide(div), .i_alt_clk_tick(alt_tick), .i_reg_index(idx),
    .i_reg_wr(wr), .i_reg_wdata(wdat), .i_reg_rd(rd), .o_reg_rdata(rdat),
    .i_cyc_start(start), .i_cyc_req(req), .o_cyc_busy(busy),
    .o_cyc_done(done), .o_cyc_rdata(crd), .i_wait_n(wait_n),
    .i_iois16_n(iois_n), .i_card_data(cdata), .o_card(card));

  card16_card_model card_i (
    .i_sys_clk(clk), .i_reset(rst), .i_card(card), .i_wait_len(wlen),
    .i_iois_en(iois_en), .i_iois_late(iois_late), .i_rd_word(16'hA5C3),
    .o_wait_n(wait_n),
    .o_iois16_n(iois_n), .o_card_data(cdata));

  // Clock at 50 MHz
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cycle counter with a ceiling against hangs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  // Alternate timing source: one pulse every fourth clock
  always @(negedge clk)
    alt_tick <= (cyc % 4 == 0);

  task automatic print_verdict;
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Lower bound on a measured count
  task automatic chk_ge(input int got, input int lo);
    checks_done++;
    if (got < lo)
    begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected min %0h", $time, got, lo);
    end
  endtask

  task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
    @(negedge clk);
    idx = i;
    wdat = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] i, input logic [7:0] exp);
    @(negedge clk);
    idx = i;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(32'(rdat), 32'(exp));
  endtask

  function automatic card16_pkg::cyc_req_type mk(input logic w, io, wd, ts,
    input logic [25:0] a, input logic [15:0] d);
    return '{w, io, wd, 1'b0, ts, a, d};
  endfunction

  // One card cycle, measuring the phases in clocks while the card is enabled
  task automatic run_cyc(input card16_pkg::cyc_req_type r);
    int   n;
    logic on, seen, waited;
    logic [3:0] strb;
    su = 0; cm = 0; rc = 0; pw = 0; n = 0;
    ce2_lo = 1'b0; ce2_early = 1'b0; held = 1'b1; seen = 1'b0; waited = 1'b0;
    // Expected active strobe {oe_n, we_n, iord_n, iowr_n} for this cycle
    strb = r.is_io ? (r.write ? 4'hE : 4'hD) : (r.write ? 4'hB : 4'h7);
    @(negedge clk);
    req = r;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    while (done !== 1'b1 && n < 1000)
    begin
      on = !(card.oe_n & card.we_n & card.iord_n & card.iowr_n);
      if (busy === 1'b1 && card.ce1_n === 1'b0)
      begin
        if (su + cm + rc == 0 && card.ce2_n === 1'b0)
          ce2_early = 1'b1;
        if (card.ce2_n === 1'b0)
          ce2_lo = 1'b1;
        if (card.addr !== r.addr || (r.write && card.data_out !== r.wdata))
          held = 1'b0;
        if (card.data_oe !== r.write || card.reg_n !== !r.reg_space)
          held = 1'b0;
        if (on && {card.oe_n, card.we_n, card.iord_n, card.iowr_n} !== strb)
          held = 1'b0;
        if (on)
        begin
          cm++;
          seen = 1'b1;
          if (wait_n === 1'b0)
            waited = 1'b1;
          else if (waited)
            pw++;
        end
        else if (seen)
          rc++;
        else
          su++;
      end
      @(negedge clk);
      n++;
    end
    chk(32'(done), 32'h1);
  endtask

  task automatic t_regs;
    reg_rd(8'h3A, 8'h00);
    reg_rd(8'h3B, 8'h07);
    reg_rd(8'h3C, 8'h04);
    reg_wr(8'h3D, 8'h02);
    reg_wr(8'h3E, 8'h03);
    reg_wr(8'h3F, 8'h01);
    reg_rd(8'h3D, 8'h02);
    reg_rd(8'h3E, 8'h03);
    reg_rd(8'h3F, 8'h01);
    reg_wr(8'h40, 8'hFF);
    reg_rd(8'h40, 8'h00);
  endtask

  task automatic t_mem;
    run_cyc(mk(1'b0, 1'b0, 1'b1, 1'b0, 26'h0001234, 16'h0000));
    chk_ge(su, 1);
    chk(32'(cm), 32'h8);
    chk_ge(rc, 6);
    chk(32'(held), 32'h1);
    chk(32'(crd), 32'hA5C3);
    run_cyc(mk(1'b1, 1'b0, 1'b1, 1'b1, 26'h3FFFFFF, 16'h5A0F));
    chk_ge(su, 3);
    chk_ge(cm, 4);
    chk_ge(rc, 3);
    chk(32'(held), 32'h1);
  endtask

  task automatic t_wait;
    // Wait outlasts the command count, so the hold after it is visible
    wlen = 8'h0A;
    run_cyc(mk(1'b0, 1'b0, 1'b1, 1'b0, 26'h0000010, 16'h0000));
    chk_ge(pw, 2);
    chk_ge(cm, 8);
    chk(32'(crd), 32'hA5C3);
    run_cyc(mk(1'b0, 1'b1, 1'b0, 1'b0, 26'h0000020, 16'h0000));
    chk_ge(pw, 3);
    chk(32'(crd), 32'h00C3);
    wlen = 8'h00;
  endtask

  task automatic t_io;
    iois_en = 1'b1;
    run_cyc(mk(1'b0, 1'b1, 1'b1, 1'b0, 26'h0000300, 16'h0000));
    chk(32'(ce2_lo), 32'h1);
    chk(32'(ce2_early), 32'h0);
    chk(32'(crd), 32'hA5C3);
    run_cyc(mk(1'b1, 1'b1, 1'b1, 1'b0, 26'h0000304, 16'h1234));
    chk(32'(ce2_lo), 32'h1);
    chk(32'(ce2_early), 32'h0);
    chk(32'(held), 32'h1);
    // Late answer: set 1 setup lasts as long as the window, so it must be ignored
    iois_late = 1'b1;
    run_cyc(mk(1'b0, 1'b1, 1'b1, 1'b1, 26'h0000306, 16'h0000));
    chk(32'(ce2_lo), 32'h0);
    chk(32'(crd), 32'h00C3);
    iois_late = 1'b0;
    iois_en = 1'b0;
    run_cyc(mk(1'b0, 1'b1, 1'b1, 1'b0, 26'h0000302, 16'h0000));
    chk(32'(ce2_lo), 32'h0);
    chk(32'(crd[15:8]), 32'h0);
  endtask

  task automatic t_clk;
    div = 1'b1;
    run_cyc(mk(1'b0, 1'b0, 1'b1, 1'b0, 26'h0000040, 16'h0000));
    chk_ge(su, 2);
    chk_ge(cm, 16);
    div = 1'b0;
    alt_sel = 1'b1;
    run_cyc(mk(1'b0, 1'b0, 1'b1, 1'b0, 26'h0000044, 16'h0000));
    chk_ge(cm, 28);
    chk_ge(su, 4);
    alt_sel = 1'b0;
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1; alt_sel = 1'b0; div = 1'b0; iois_late = 1'b0;
    idx = 8'h00; wr = 1'b0; wdat = 8'h00; rd = 1'b0; start = 1'b0;
    req = '0; wlen = 8'h00; iois_en = 1'b0;
    n_mismatch = 0; checks_done = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_mem();
    t_wait();
    t_io();
    t_clk();
    print_verdict();
  end
endmodule
